// *** timers_pkg.sv ***
// Register map, field layout, codes and reset values of the two
// reload down-timers. Shared by the timer core and its register shell.
package timers_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'h1b;
	localparam logic [7:0] ADDR_T2_COUNT_HI  = 8'h1c;
	localparam logic [7:0] ADDR_T2_COUNT_LO  = 8'h1d;
	localparam logic [7:0] ADDR_T3_CONTROL   = 8'h1e;
	localparam logic [7:0] ADDR_T3_RELOAD_HI = 8'h1f;
	localparam logic [7:0] ADDR_T3_RELOAD_LO = 8'h20;
	localparam logic [7:0] ADDR_T3_COUNT_HI  = 8'h21;
	localparam logic [7:0] ADDR_T3_COUNT_LO  = 8'h22;
	localparam logic [7:0] ADDR_T2_RELOAD_HI = 8'h40;
	localparam logic [7:0] ADDR_T2_CONTROL   = 8'h41;
	localparam logic [7:0] ADDR_COMMAND      = 8'h42;
	localparam logic [7:0] ADDR_STATUS       = 8'h43;

	// Control register fields
	localparam int CTL_STOP_RX = 7;
	localparam int CTL_MODE_HI = 5;
	localparam int CTL_MODE_LO = 4;
	localparam int CTL_AUTO    = 3;
	localparam int CTL_CLK_HI  = 1;
	localparam int CTL_CLK_LO  = 0;
	localparam logic [7:0] T3_CTL_WR_MASK = 8'hbb;
	localparam logic [7:0] T2_CTL_WR_MASK = 8'h3b;

	// Start modes
	localparam logic [1:0] MODE_HOST    = 2'b00;
	localparam logic [1:0] MODE_TX_END  = 2'b01;
	localparam logic [1:0] MODE_TRIM    = 2'b10;
	localparam logic [1:0] MODE_TRIM_UF = 2'b11;

	// Count clock sources
	localparam logic [1:0] CLK_CARRIER    = 2'b00;
	localparam logic [1:0] CLK_SUBCARRIER = 2'b01;
	localparam logic [1:0] CLK_TMR0_UF    = 2'b10;
	localparam logic [1:0] CLK_TMR1_UF    = 2'b11;

	// Command and status bits
	localparam int CMD_START2 = 0;
	localparam int CMD_STOP2  = 1;
	localparam int CMD_START3 = 2;
	localparam int CMD_STOP3  = 3;
	localparam int STS_IRQ2   = 0;
	localparam int STS_IRQ3   = 1;
	localparam int STS_RUN2   = 2;
	localparam int STS_RUN3   = 3;

	// Reset values
	localparam logic [7:0]  REG_RST   = 8'h00;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	typedef enum logic {
		TMR_IDLE = 1'b0,
		TMR_RUN  = 1'b1
	} run_state_t;

endpackage

// *** down_timer_core.sv ***
// One 16-bit reload down-counter with start, stop and auto reload.
// Assumes start, stop and tick are single-cycle pulses on sys_clk_i.
`timescale 1ns/1ps
module down_timer_core
	import timers_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        start_i,
	input  wire logic        stop_i,
	input  wire logic        tick_i,
	input  wire logic [15:0] reload_i,
	input  wire logic        auto_reload_i,
	input  wire logic        uflow_en_i,
	output logic      [15:0] count_o,
	output logic             running_o,
	output logic             underflow_o
);

	run_state_t  state_ff;
	logic [15:0] count_ff;
	logic        uf_ff;

	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			state_ff <= TMR_IDLE;
			count_ff <= COUNT_RST;
			uf_ff    <= 1'b0;
		end
		else
		begin
			uf_ff <= 1'b0;
			if (start_i)
			begin
				// Reload registers reach the counter here and on auto reload at underflow
				count_ff <= reload_i;
				state_ff <= TMR_RUN;
			end
			else if (stop_i)
				state_ff <= TMR_IDLE;
			else
				case (state_ff)
					TMR_IDLE:
						state_ff <= TMR_IDLE;
					TMR_RUN:
						if (tick_i)
						begin
							if (count_ff == COUNT_ONE && uflow_en_i)
							begin
								uf_ff <= 1'b1;
								if (auto_reload_i)
									count_ff <= reload_i;
								else
								begin
									count_ff <= COUNT_RST;
									state_ff <= TMR_IDLE;
								end
							end
							else if (count_ff <= COUNT_ONE)
							begin
								// Zero reached without underflow
								count_ff <= COUNT_RST;
								state_ff <= TMR_IDLE;
							end
							else
								count_ff <= count_ff - COUNT_ONE;
						end
					default:
						state_ff <= TMR_IDLE;
				endcase
		end
	end

	assign count_o     = count_ff;
	assign running_o   = (state_ff == TMR_RUN);
	assign underflow_o = uf_ff;

endmodule

// *** dual_reload_down_timers.sv ***
// Register shell and start/stop control of two reload down-timers.
// Assumes tick, underflow, transmit-end and receive inputs are
// one-cycle pulses on sys_clk_i; the oscillator input is asynchronous.
//
// Overview of operation
// - Start loads second timer from both reload bytes
// - Start loads third timer from both reload bytes
// - Second timer live count readable; avoid during reception
// - Third timer live count readable; avoid during reception
// - Stop-on-receive halts third timer after four bits
// - Stop-on-receive ignored in oscillator trimming modes
// - Mode 00 manual; 01 starts at transmit end
// - Modes 10/11 trim oscillator, start/stop on rising edge
// - Auto reload restarts at zero except in third timer mode 10, otherwise stops
// - Third timer underflow sets its interrupt flag
// - Clock select picks carrier, subcarrier, timer0, timer1
// - Second timer mode 01 starts at transmit end
// - Second timer auto reload, underflow sets its flag
`timescale 1ns/1ps
module dual_reload_down_timers
	import timers_pkg::*;
(
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       tick_carrier_i,
	input  wire logic       tick_subcarrier_i,
	input  wire logic       timer0_underflow_i,
	input  wire logic       timer1_underflow_i,
	input  wire logic       tx_end_i,
	input  wire logic       rx_first_bits_i,
	input  wire logic       low_frequency_oscillator_i,
	output logic            second_timer_irq_o,
	output logic            timer_underflow_irq_flag_o
);

	function automatic logic select_tick(input logic [1:0] sel,
		input logic car, input logic sub,
		input logic uf0, input logic uf1);
		logic t;
		t = 1'b0;
		case (sel)
			CLK_CARRIER:    t = car;
			CLK_SUBCARRIER: t = sub;
			CLK_TMR0_UF:    t = uf0;
			default:        t = uf1;
		endcase
		return t;
	endfunction

	logic [7:0]  t2_reload_lo_ff;
	logic [7:0]  t2_reload_hi_ff;
	logic [7:0]  t2_control_ff;
	logic [7:0]  t3_control_ff;
	logic [7:0]  t3_reload_hi_ff;
	logic [7:0]  t3_reload_lo_ff;
	logic [7:0]  rdata_ff;
	logic        irq2_ff;
	logic        irq3_ff;
	logic        lfo_meta_ff;
	logic        lfo_s2_ff;
	logic        lfo_s3_ff;
	logic        lfo_level_ff;
	logic        lfo_rise;
	logic [15:0] t2_reload;
	logic [15:0] t3_reload;
	logic [15:0] t2_count;
	logic [15:0] t3_count;
	logic        t2_run;
	logic        t3_run;
	logic        t2_uf;
	logic        t3_uf;
	logic        cmd_wr;
	logic        sts_wr;
	logic [1:0]  t2_mode;
	logic [1:0]  t3_mode;
	logic        t3_trim;
	logic        t3_uflow_en;
	logic        t2_tick;
	logic        t3_tick;
	logic        t2_start;
	logic        t2_stop;
	logic        t3_start;
	logic        t3_stop;

	// Oscillator pin: three flops, level accepted once stages 2 and 3 agree
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			lfo_meta_ff  <= 1'b0;
			lfo_s2_ff    <= 1'b0;
			lfo_s3_ff    <= 1'b0;
			lfo_level_ff <= 1'b0;
		end
		else
		begin
			lfo_meta_ff <= low_frequency_oscillator_i;
			lfo_s2_ff   <= lfo_meta_ff;
			lfo_s3_ff   <= lfo_s2_ff;
			if (lfo_s2_ff == lfo_s3_ff)
				lfo_level_ff <= lfo_s3_ff;
		end
	end

	assign lfo_rise = (lfo_s2_ff == lfo_s3_ff) && lfo_s3_ff && !lfo_level_ff;

	assign cmd_wr = reg_wr_i && (reg_addr_i == ADDR_COMMAND);
	assign sts_wr = reg_wr_i && (reg_addr_i == ADDR_STATUS);

	// Register writes
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			t2_reload_lo_ff <= REG_RST;
			t2_reload_hi_ff <= REG_RST;
			t2_control_ff   <= REG_RST;
			t3_control_ff   <= REG_RST;
			t3_reload_hi_ff <= REG_RST;
			t3_reload_lo_ff <= REG_RST;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == ADDR_T2_RELOAD_LO)
				t2_reload_lo_ff <= reg_wdata_i;
			else if (reg_addr_i == ADDR_T2_RELOAD_HI)
				t2_reload_hi_ff <= reg_wdata_i;
			else if (reg_addr_i == ADDR_T2_CONTROL)
				t2_control_ff <= reg_wdata_i & T2_CTL_WR_MASK;
			else if (reg_addr_i == ADDR_T3_CONTROL)
				t3_control_ff <= reg_wdata_i & T3_CTL_WR_MASK;
			else if (reg_addr_i == ADDR_T3_RELOAD_HI)
				t3_reload_hi_ff <= reg_wdata_i;
			else if (reg_addr_i == ADDR_T3_RELOAD_LO)
				t3_reload_lo_ff <= reg_wdata_i;
		end
	end

	assign t2_reload = {t2_reload_hi_ff, t2_reload_lo_ff};
	assign t3_reload = {t3_reload_hi_ff, t3_reload_lo_ff};
	assign t2_mode   = t2_control_ff[CTL_MODE_HI:CTL_MODE_LO];
	assign t3_mode   = t3_control_ff[CTL_MODE_HI:CTL_MODE_LO];
	assign t3_trim   = t3_mode[1];
	assign t3_uflow_en = (t3_mode != MODE_TRIM);

	assign t2_tick = select_tick(t2_control_ff[CTL_CLK_HI:CTL_CLK_LO],
		tick_carrier_i, tick_subcarrier_i,
		timer0_underflow_i, timer1_underflow_i);
	assign t3_tick = select_tick(t3_control_ff[CTL_CLK_HI:CTL_CLK_LO],
		tick_carrier_i, tick_subcarrier_i,
		timer0_underflow_i, timer1_underflow_i);

	// Start and stop events
	assign t2_start = (cmd_wr && reg_wdata_i[CMD_START2])
		|| (t2_mode == MODE_TX_END && tx_end_i);
	assign t2_stop  = cmd_wr && reg_wdata_i[CMD_STOP2];
	assign t3_start = (cmd_wr && reg_wdata_i[CMD_START3])
		|| (t3_mode == MODE_TX_END && tx_end_i)
		|| (t3_trim && lfo_rise && !t3_run);
	assign t3_stop  = (cmd_wr && reg_wdata_i[CMD_STOP3])
		|| (t3_control_ff[CTL_STOP_RX] && !t3_trim
			&& rx_first_bits_i)
		|| (t3_trim && lfo_rise && t3_run);

	down_timer_core u_second_timer (
		.sys_clk_i     (sys_clk_i),
		.rst_n_i       (rst_n_i),
		.start_i       (t2_start),
		.stop_i        (t2_stop),
		.tick_i        (t2_tick),
		.reload_i      (t2_reload),
		.auto_reload_i (t2_control_ff[CTL_AUTO]),
		.uflow_en_i    (1'b1),
		.count_o       (t2_count),
		.running_o     (t2_run),
		.underflow_o   (t2_uf)
	);

	down_timer_core u_third_timer (
		.sys_clk_i     (sys_clk_i),
		.rst_n_i       (rst_n_i),
		.start_i       (t3_start),
		.stop_i        (t3_stop),
		.tick_i        (t3_tick),
		.reload_i      (t3_reload),
		.auto_reload_i (t3_control_ff[CTL_AUTO]),
		.uflow_en_i    (t3_uflow_en),
		.count_o       (t3_count),
		.running_o     (t3_run),
		.underflow_o   (t3_uf)
	);

	// Sticky flags, write one to clear; a new underflow beats the clear
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
		begin
			irq2_ff <= 1'b0;
			irq3_ff <= 1'b0;
		end
		else
		begin
			irq2_ff <= t2_uf
				|| (irq2_ff && !(sts_wr && reg_wdata_i[STS_IRQ2]));
			irq3_ff <= t3_uf
				|| (irq3_ff && !(sts_wr && reg_wdata_i[STS_IRQ3]));
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk_i)
	begin
		if (!rst_n_i)
			rdata_ff <= REG_RST;
		else if (!reg_rd_i)
			rdata_ff <= REG_RST;
		else if (reg_addr_i == ADDR_T2_RELOAD_LO)
			rdata_ff <= t2_reload_lo_ff;
		else if (reg_addr_i == ADDR_T2_COUNT_HI)
			rdata_ff <= t2_count[15:8];
		else if (reg_addr_i == ADDR_T2_COUNT_LO)
			rdata_ff <= t2_count[7:0];
		else if (reg_addr_i == ADDR_T3_CONTROL)
			rdata_ff <= t3_control_ff & T3_CTL_WR_MASK;
		else if (reg_addr_i == ADDR_T3_RELOAD_HI)
			rdata_ff <= t3_reload_hi_ff;
		else if (reg_addr_i == ADDR_T3_RELOAD_LO)
			rdata_ff <= t3_reload_lo_ff;
		else if (reg_addr_i == ADDR_T3_COUNT_HI)
			rdata_ff <= t3_count[15:8];
		else if (reg_addr_i == ADDR_T3_COUNT_LO)
			rdata_ff <= t3_count[7:0];
		else if (reg_addr_i == ADDR_T2_RELOAD_HI)
			rdata_ff <= t2_reload_hi_ff;
		else if (reg_addr_i == ADDR_T2_CONTROL)
			rdata_ff <= t2_control_ff;
		else if (reg_addr_i == ADDR_STATUS)
			rdata_ff <= {4'h0, t3_run, t2_run, irq3_ff, irq2_ff};
		else
			rdata_ff <= REG_RST;
	end

	assign reg_rdata_o                = rdata_ff;
	assign second_timer_irq_o         = irq2_ff;
	assign timer_underflow_irq_flag_o = irq3_ff;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_t2_start_load: assert property (
		t2_start |=> t2_run && t2_count == $past(t2_reload))
		else $error("second timer not loaded on start");

	a_t3_start_load: assert property (
		t3_start |=> t3_run && t3_count == $past(t3_reload))
		else $error("third timer not loaded on start");

	a_t2_count_read: assert property (
		reg_rd_i && reg_addr_i == ADDR_T2_COUNT_LO
		|=> reg_rdata_o == $past(t2_count[7:0]))
		else $error("second timer low count read wrong");

	a_t3_count_read: assert property (
		reg_rd_i && reg_addr_i == ADDR_T3_COUNT_HI
		|=> reg_rdata_o == $past(t3_count[15:8]))
		else $error("third timer high count read wrong");

	a_rx_stop_halt: assert property (
		t3_control_ff[CTL_STOP_RX] && !t3_trim && rx_first_bits_i
		&& !t3_start |=> !t3_run)
		else $error("third timer kept running after receive stop");

	a_trim_rx_ignored: assert property (
		t3_run && t3_trim && rx_first_bits_i && !lfo_rise
		&& !(cmd_wr && reg_wdata_i[CMD_STOP3]) && !t3_tick
		&& !(cmd_wr && reg_wdata_i[CMD_START3])
		|=> t3_run && $stable(t3_count))
		else $error("receive stop acted in trimming mode");

	a_host_mode_idle: assert property (
		t3_mode == MODE_HOST && !t3_run && tx_end_i
		&& !(cmd_wr && reg_wdata_i[CMD_START3]) |=> !t3_run)
		else $error("third timer started itself in host mode");

	a_tx_end_start: assert property (
		t3_mode == MODE_TX_END && tx_end_i |=> t3_run)
		else $error("third timer missed transmit end start");

	a_trim_edge_start: assert property (
		t3_trim && !t3_run && lfo_rise
		|=> t3_run && t3_count == $past(t3_reload))
		else $error("trimming edge did not start third timer");

	a_auto_reload: assert property (
		t3_run && t3_tick && t3_count == COUNT_ONE && t3_uflow_en
		&& t3_control_ff[CTL_AUTO] && !t3_start && !t3_stop
		|=> t3_run && t3_count == $past(t3_reload) ##1 irq3_ff)
		else $error("third timer did not reload at zero");

	a_stop_at_zero: assert property (
		t3_run && t3_tick && t3_count == COUNT_ONE
		&& !t3_control_ff[CTL_AUTO] && !t3_start && !t3_stop
		|=> !t3_run && t3_count == COUNT_RST)
		else $error("third timer did not stop at zero");

	a_uf_flag_set: assert property (
		t3_uf |=> irq3_ff)
		else $error("underflow flag not set");

	a_trim_no_uf: assert property (
		t3_mode == MODE_TRIM |=> !t3_uf)
		else $error("underflow seen in trimming without underflow");

	a_clk_sel_hold: assert property (
		t3_run && t3_control_ff[CTL_CLK_HI:CTL_CLK_LO] == CLK_TMR0_UF
		&& !timer0_underflow_i && !t3_start && !t3_stop
		|=> $stable(t3_count))
		else $error("third timer counted without timer0 underflow");

	a_t2_tx_start: assert property (
		t2_mode == MODE_TX_END && tx_end_i |=> t2_run)
		else $error("second timer missed transmit end start");

	a_t2_uf_flag: assert property (
		t2_uf |=> second_timer_irq_o)
		else $error("second timer flag not set");

	a_decrement: assert property (
		t3_run && t3_tick && t3_count > COUNT_ONE
		&& !t3_start && !t3_stop
		|=> t3_count == $past(t3_count) - COUNT_ONE)
		else $error("third timer did not decrement by one");

	a_reserved_zero: assert property (
		reg_rd_i && reg_addr_i == ADDR_T3_CONTROL
		|=> reg_rdata_o[6] == 1'b0 && reg_rdata_o[2] == 1'b0)
		else $error("reserved control bits read nonzero");

	c_t3_underflow: cover property (t3_start ##[1:300] t3_uf);
	c_auto_restart: cover property (
		t3_uf && t3_control_ff[CTL_AUTO] ##1 t3_run);
	c_rx_stop: cover property (t3_run ##1 rx_first_bits_i ##1 !t3_run);
	c_trim_cycle: cover property (
		t3_trim && t3_start ##[1:300] t3_stop);

endmodule

// *** tb.sv ***
// Self-checking bench for the two reload down-timers.
// Drives the register port, ticks and events itself; no far-side model.
`timescale 1ns/1ps
module tb;
	import timers_pkg::*;

	logic       sys_clk_i;
	logic       rst_n_i;
	logic [7:0] reg_addr_i;
	logic [7:0] reg_wdata_i;
	logic       reg_wr_i;
	logic       reg_rd_i;
	logic [7:0] reg_rdata_o;
	logic [5:0] pul;
	logic       low_frequency_oscillator;
	logic       irq2;
	logic       irq3;
	int         failures;
	int         samples_checked;
	int         cycles;

	dual_reload_down_timers u_dut (
		.sys_clk_i                  (sys_clk_i),
		.rst_n_i                    (rst_n_i),
		.reg_addr_i                 (reg_addr_i),
		.reg_wdata_i                (reg_wdata_i),
		.reg_wr_i                   (reg_wr_i),
		.reg_rd_i                   (reg_rd_i),
		.reg_rdata_o                (reg_rdata_o),
		.tick_carrier_i             (pul[0]),
		.tick_subcarrier_i          (pul[1]),
		.timer0_underflow_i         (pul[2]),
		.timer1_underflow_i         (pul[3]),
		.tx_end_i                   (pul[4]),
		.rx_first_bits_i            (pul[5]),
		.low_frequency_oscillator_i (low_frequency_oscillator),
		.second_timer_irq_o         (irq2),
		.timer_underflow_irq_flag_o (irq3)
	);

	always #25 sys_clk_i = ~sys_clk_i;

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge sys_clk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			stop_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe edge
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
		chk({8'h00, d}, {8'h00, e});
	endtask

	task automatic pulse(input int i, input int n);
		repeat (n)
		begin
			@(posedge sys_clk_i);
			pul[i] <= 1'b1;
			@(posedge sys_clk_i);
			pul[i] <= 1'b0;
		end
		repeat (3) @(posedge sys_clk_i);
	endtask

	task automatic lfo_rise();
		@(posedge sys_clk_i);
		low_frequency_oscillator <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		low_frequency_oscillator <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
	endtask

	task automatic test_regs();
		chk_reg(8'h1e, 8'h00);
		wr(8'h1e, 8'hff);
		chk_reg(8'h1e, 8'hbb);
		wr(8'h1e, 8'h00);
		wr(8'h1f, 8'ha5);
		chk_reg(8'h1f, 8'ha5);
		wr(8'h20, 8'h5a);
		chk_reg(8'h20, 8'h5a);
		wr(8'h1b, 8'h3c);
		chk_reg(8'h1b, 8'h3c);
		chk_reg(8'h30, 8'h00);
		$display("test regs done");
	endtask

	task automatic test_load();
		wr(8'h1f, 8'h00);
		wr(8'h20, 8'h03);
		wr(8'h42, 8'h04);
		chk_reg(8'h21, 8'h00);
		chk_reg(8'h22, 8'h03);
		wr(8'h20, 8'h10);
		pulse(0, 1);
		chk_reg(8'h22, 8'h02);
		pulse(0, 2);
		chk({15'h0000, irq3}, 16'h0001);
		chk_reg(8'h22, 8'h00);
		chk_reg(8'h43, 8'h02);
		wr(8'h43, 8'h02);
		repeat (2) @(posedge sys_clk_i);
		chk({15'h0000, irq3}, 16'h0000);
		$display("test load done");
	endtask

	task automatic test_clk();
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h1e, 8'(s));
			wr(8'h42, 8'h04);
			for (int o = 0; o < 4; o++)
				if (o != s)
					pulse(o, 1);
			pulse(s, 1);
			chk_reg(8'h22, 8'h0f);
			wr(8'h42, 8'h08);
		end
		$display("test clock select done");
	endtask

	task automatic test_auto();
		wr(8'h1e, 8'h08);
		wr(8'h20, 8'h02);
		wr(8'h42, 8'h04);
		pulse(0, 2);
		chk_reg(8'h22, 8'h02);
		chk_reg(8'h43, 8'h0a);
		wr(8'h43, 8'h02);
		wr(8'h42, 8'h08);
		$display("test auto reload done");
	endtask

	task automatic test_tx();
		wr(8'h1b, 8'h05);
		wr(8'h40, 8'h00);
		wr(8'h41, 8'h10);
		wr(8'h1e, 8'h10);
		pulse(4, 1);
		chk_reg(8'h1d, 8'h05);
		chk_reg(8'h22, 8'h02);
		chk_reg(8'h43, 8'h0c);
		wr(8'h1b, 8'h07);
		pulse(0, 1);
		chk_reg(8'h1d, 8'h04);
		chk_reg(8'h1c, 8'h00);
		wr(8'h42, 8'h0a);
		wr(8'h41, 8'h00);
		wr(8'h1e, 8'h00);
		pulse(4, 1);
		chk_reg(8'h43, 8'h00);
		$display("test transmit end done");
	endtask

	task automatic test_rx();
		wr(8'h20, 8'h05);
		wr(8'h1e, 8'h90);
		pulse(4, 1);
		pulse(0, 1);
		pulse(5, 1);
		chk_reg(8'h43, 8'h00);
		pulse(0, 1);
		chk_reg(8'h22, 8'h04);
		wr(8'h1e, 8'h10);
		pulse(4, 1);
		pulse(5, 1);
		chk_reg(8'h43, 8'h08);
		wr(8'h42, 8'h08);
		wr(8'h1e, 8'hb0);
		lfo_rise();
		pulse(5, 1);
		chk_reg(8'h43, 8'h08);
		lfo_rise();
		chk_reg(8'h43, 8'h00);
		$display("test stop on receive done");
	endtask

	task automatic test_trim();
		wr(8'h20, 8'h01);
		wr(8'h1e, 8'h20);
		lfo_rise();
		chk_reg(8'h43, 8'h08);
		pulse(0, 1);
		chk_reg(8'h22, 8'h00);
		chk_reg(8'h43, 8'h00);
		chk({15'h0000, irq3}, 16'h0000);
		wr(8'h1e, 8'h00);
		$display("test trimming done");
	endtask

	task automatic test_t2();
		wr(8'h1b, 8'h01);
		wr(8'h41, 8'h08);
		wr(8'h42, 8'h01);
		pulse(0, 1);
		chk({15'h0000, irq2}, 16'h0001);
		chk_reg(8'h1d, 8'h01);
		chk_reg(8'h43, 8'h05);
		wr(8'h43, 8'h01);
		wr(8'h42, 8'h02);
		repeat (2) @(posedge sys_clk_i);
		chk({15'h0000, irq2}, 16'h0000);
		$display("test second timer done");
	endtask

	initial
	begin
		sys_clk_i = 1'b0;
		rst_n_i = 1'b0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		pul = 6'h00;
		low_frequency_oscillator = 1'b0;
		failures = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		test_regs();
		test_load();
		test_clk();
		test_auto();
		test_tx();
		test_rx();
		test_trim();
		test_t2();
		stop_test();
	end
endmodule
